// *** core/sdf_pkg.sv ***
package sdf_pkg;

    // Modulator strobe divider: one sample every 128 master clocks.
    localparam int MOD_DIV = 128;
    localparam int DIV_W = 7;
    localparam logic [DIV_W-1:0] MOD_LAST = 7'h7f;

    // Decimation ratios for the four rate select codes.
    localparam int DEC_W = 9;
    localparam logic [DEC_W-1:0] DEC_N_0 = 9'h180;
    localparam logic [DEC_W-1:0] DEC_N_1 = 9'h140;
    localparam logic [DEC_W-1:0] DEC_N_2 = 9'h050;
    localparam logic [DEC_W-1:0] DEC_N_3 = 9'h028;

    // Accumulator width covers 3*log2(Nmax) of growth plus sign and margin.
    localparam int ACC_W = 30;
    localparam int PROD_W = 57;
    localparam int RECIP_W = 26;
    localparam int RECIP_SH = 24;
    localparam logic [63:0] RECIP_NUM = 64'h0000_0100_0000_0000;
    localparam logic [RECIP_W-1:0] RECIP_0 = RECIP_W'(RECIP_NUM / (64'd384 * 64'd384 * 64'd384));
    localparam logic [RECIP_W-1:0] RECIP_1 = RECIP_W'(RECIP_NUM / (64'd320 * 64'd320 * 64'd320));
    localparam logic [RECIP_W-1:0] RECIP_2 = RECIP_W'(RECIP_NUM / (64'd80 * 64'd80 * 64'd80));
    localparam logic [RECIP_W-1:0] RECIP_3 = RECIP_W'(RECIP_NUM / (64'd40 * 64'd40 * 64'd40));

    localparam int OUT_W = 16;
    localparam logic signed [32:0] MIDSCALE = 33'sh0_0000_8000;
    localparam logic signed [32:0] FULLSCALE = 33'sh0_0000_ffff;

    // Output words, the last of them delivered, before data counts as settled.
    localparam logic [2:0] SETTLE_STEP_WORDS = 3'h4;
    localparam logic [2:0] SETTLE_SYNC_WORDS = 3'h3;

    localparam int FIFO_DEPTH = 16;

    // Register map, byte addresses.
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h8;
    localparam int CTRL_RATE_LO_BIT = 0;
    localparam int CTRL_RATE_HI_BIT = 1;
    localparam int CTRL_BIPOLAR_BIT = 2;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;
    localparam int ST_SETTLED_BIT = 0;
    localparam int ST_AVAIL_BIT = 1;
    localparam int ST_OVERRUN_BIT = 2;
    localparam int ST_LEVEL_LSB = 8;

    typedef enum logic [1:0] {
        SDF_IDLE,
        SDF_SETTLE,
        SDF_RUN
    } sdf_state_t;

endpackage

// *** core/sdf_mod_tick.sv ***
`timescale 1ns/10ps
module sdf_mod_tick import sdf_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    output logic tick
);

    logic [DIV_W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (cnt_ff == MOD_LAST);
        end
    end

    assign tick = tick_ff;

endmodule

// *** core/sdf_fifo.sv ***
`timescale 1ns/10ps
module sdf_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] level_ff;
    logic push;
    logic pop;

    assign in_ready = (level_ff != (AW+1)'(DEPTH));
    assign out_valid = (level_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_ready && out_valid;
    assign out_data = mem[rd_ptr_ff];
    assign level = level_ff;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                level_ff <= level_ff + 1'b1;
            end else if (pop && !push) begin
                level_ff <= level_ff - 1'b1;
            end
        end
    end

endmodule

// *** core/sdf_filter.sv ***
// Operation
// - Output is the cube of an N-tap moving sum, scaled by 1/N^3.
// - A new output word appears once per first-notch period.
// - Two-bit rate select picks N, moving notches without changing shape.
// - Nulls sit at every multiple of the first notch, deeper than 100 dB.
// - After an unsynchronised step, up to four output words are invalid; here a config change discards three words and delivers the fourth.
// - With filter sync, the filter settles within three output words.
// - Datapath carries 5% overrange without internal saturation.
// - Polarity bit alters only output coding and calibration points; here a change also restarts settling.
// - No rejection around multiples of the modulator sample rate.
// - Modulator samples are taken at one 128th of the master clock.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
module sdf_filter import sdf_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mod_bit,
    input wire logic filter_sync,
    output logic mod_sample,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic data_avail
);

    function automatic logic [DEC_W-1:0] dec_n(input logic [1:0] sel);
        case (sel)
            2'h0: dec_n = DEC_N_0;
            2'h1: dec_n = DEC_N_1;
            2'h2: dec_n = DEC_N_2;
            default: dec_n = DEC_N_3;
        endcase
    endfunction

    function automatic logic [RECIP_W-1:0] recip(input logic [1:0] sel);
        case (sel)
            2'h0: recip = RECIP_0;
            2'h1: recip = RECIP_1;
            2'h2: recip = RECIP_2;
            default: recip = RECIP_3;
        endcase
    endfunction

    function automatic logic [OUT_W-1:0] clamp(input logic signed [32:0] v);
        if (v < 0) begin
            clamp = '0;
        end else if (v > FULLSCALE) begin
            clamp = '1;
        end else begin
            clamp = v[OUT_W-1:0];
        end
    endfunction

    logic rate_select_lo_ff;
    logic rate_select_hi_ff;
    logic bipolar_ff;
    logic enable_ff;
    logic [1:0] rate_sel;
    logic ctrl_wr;
    logic cfg_change;
    logic filter_clear;

    logic signed [ACC_W-1:0] int1_ff;
    logic signed [ACC_W-1:0] int2_ff;
    logic signed [ACC_W-1:0] int3_ff;
    logic signed [ACC_W-1:0] dly1_ff;
    logic signed [ACC_W-1:0] dly2_ff;
    logic signed [ACC_W-1:0] dly3_ff;
    logic signed [ACC_W-1:0] sum_ff;
    logic signed [ACC_W-1:0] in_step;
    logic signed [ACC_W-1:0] comb1;
    logic signed [ACC_W-1:0] comb2;
    logic [DEC_W-1:0] phase_ff;
    logic [DEC_W-1:0] n_cur;
    logic last_phase;
    logic dec_stb_ff;

    sdf_state_t state_ff;
    logic [2:0] settle_cnt_ff;
    logic deliver;

    logic signed [PROD_W-1:0] prod;
    logic [PROD_W-1:0] prod_ru;
    logic [PROD_W-1:0] prod_rb;
    logic signed [32:0] uni_val;
    logic signed [32:0] bip_val;
    logic [OUT_W-1:0] code_ff;
    logic scale_stb_ff;

    logic hold_valid_ff;
    logic [OUT_W-1:0] hold_ff;
    logic overrun_ff;
    logic overrun_evt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [OUT_W-1:0] fifo_out_data;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic [31:0] rdata_ff;
    logic avail_ff;

    sdf_mod_tick u_tick (
        .mclk(mclk),
        .rst(rst),
        .tick(mod_sample)
    );

    // Control register and configuration changes.
    assign rate_sel = {rate_select_hi_ff, rate_select_lo_ff};
    assign ctrl_wr = reg_wr && (reg_addr == ADDR_CTRL);
    assign cfg_change = ctrl_wr && enable_ff && reg_wdata[CTRL_ENABLE_BIT] &&
        ({reg_wdata[CTRL_BIPOLAR_BIT], reg_wdata[CTRL_RATE_HI_BIT], reg_wdata[CTRL_RATE_LO_BIT]} !=
         {bipolar_ff, rate_sel});
    assign filter_clear = filter_sync || !enable_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {enable_ff, bipolar_ff, rate_select_hi_ff, rate_select_lo_ff} <= CTRL_RESET;
        end else if (ctrl_wr) begin
            rate_select_lo_ff <= reg_wdata[CTRL_RATE_LO_BIT];
            rate_select_hi_ff <= reg_wdata[CTRL_RATE_HI_BIT];
            bipolar_ff <= reg_wdata[CTRL_BIPOLAR_BIT];
            enable_ff <= reg_wdata[CTRL_ENABLE_BIT];
        end
    end

    // Each modulator bit becomes +1 or -1; the bitstream is sampled only on the divided strobe.
    assign in_step = mod_bit ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};

    // Integrators wrap modulo 2^ACC_W; the combs undo the wrap exactly.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int1_ff <= '0;
            int2_ff <= '0;
            int3_ff <= '0;
        end else if (filter_clear) begin
            int1_ff <= '0;
            int2_ff <= '0;
            int3_ff <= '0;
        end else if (mod_sample) begin
            int1_ff <= int1_ff + in_step;
            int2_ff <= int2_ff + int1_ff;
            int3_ff <= int3_ff + int2_ff;
        end
    end

    assign n_cur = dec_n(rate_sel);
    assign last_phase = mod_sample && (phase_ff == n_cur - 1'b1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_ff <= '0;
        end else if (filter_clear || cfg_change) begin
            phase_ff <= '0;
        end else if (mod_sample) begin
            phase_ff <= last_phase ? '0 : phase_ff + 1'b1;
        end
    end

    assign comb1 = int3_ff - dly1_ff;
    assign comb2 = comb1 - dly2_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dly1_ff <= '0;
            dly2_ff <= '0;
            dly3_ff <= '0;
            sum_ff <= '0;
        end else if (filter_clear) begin
            dly1_ff <= '0;
            dly2_ff <= '0;
            dly3_ff <= '0;
            sum_ff <= '0;
        end else if (last_phase) begin
            // Three N-sample differences give zeros at every multiple of fmod/N.
            dly1_ff <= int3_ff;
            dly2_ff <= comb1;
            dly3_ff <= comb2;
            sum_ff <= comb2 - dly3_ff;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_stb_ff <= 1'b0;
        end else begin
            dec_stb_ff <= last_phase && !filter_clear;
        end
    end

    // Settling: words are discarded until the state window has refilled.
    assign deliver = dec_stb_ff && !filter_clear && !cfg_change &&
        ((state_ff == SDF_RUN) || ((state_ff == SDF_SETTLE) && (settle_cnt_ff <= 3'h1)));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= SDF_IDLE;
            settle_cnt_ff <= SETTLE_SYNC_WORDS;
        end else if (filter_clear) begin
            state_ff <= enable_ff ? SDF_SETTLE : SDF_IDLE;
            settle_cnt_ff <= SETTLE_SYNC_WORDS;
        end else if (cfg_change) begin
            state_ff <= SDF_SETTLE;
            settle_cnt_ff <= SETTLE_STEP_WORDS;
        end else begin
            case (state_ff)
                SDF_IDLE: begin
                    state_ff <= SDF_SETTLE;
                end
                SDF_SETTLE: begin
                    if (dec_stb_ff) begin
                        settle_cnt_ff <= settle_cnt_ff - 1'b1;
                        if (settle_cnt_ff <= 3'h1) begin
                            state_ff <= SDF_RUN;
                        end
                    end
                end
                SDF_RUN: begin
                    settle_cnt_ff <= '0;
                end
                default: begin
                    state_ff <= SDF_IDLE;
                end
            endcase
        end
    end

    // Scaling by 2^40/N^3 replaces the 1/N^3 divide with one multiply.
    assign prod = PROD_W'(sum_ff) * PROD_W'(signed'({1'b0, recip(rate_sel)}));
    // Half an output step is added before the shift, so the truncated reciprocal drops an exact code by one only for unipolar codes over 38836 at N=320.
    assign prod_ru = prod + (PROD_W'(1) << (RECIP_SH - 1));
    assign prod_rb = prod + (PROD_W'(1) << RECIP_SH);
    assign uni_val = prod_ru[PROD_W-1:RECIP_SH];
    assign bip_val = {prod_rb[PROD_W-1], prod_rb[PROD_W-1:RECIP_SH+1]} + MIDSCALE;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_ff <= '0;
            scale_stb_ff <= 1'b0;
        end else begin
            scale_stb_ff <= deliver;
            if (deliver) begin
                code_ff <= bipolar_ff ? clamp(bip_val) : clamp(uni_val);
            end
        end
    end

    // A full FIFO stalls the holding stage; a newer word then replaces the held one.
    assign overrun_evt = scale_stb_ff && hold_valid_ff && !fifo_in_ready;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_valid_ff <= 1'b0;
            hold_ff <= '0;
        end else if (scale_stb_ff) begin
            hold_valid_ff <= 1'b1;
            hold_ff <= code_ff;
        end else if (fifo_in_ready) begin
            hold_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            overrun_ff <= 1'b0;
        end else if (overrun_evt) begin
            overrun_ff <= 1'b1;
        end else if (reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[ST_OVERRUN_BIT]) begin
            overrun_ff <= 1'b0;
        end
    end

    sdf_fifo #(
        .W(OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(hold_valid_ff),
        .in_ready(fifo_in_ready),
        .in_data(hold_ff),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign fifo_pop = reg_rd && (reg_addr == ADDR_DATA) && fifo_out_valid;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_CTRL: begin
                        rdata_ff[CTRL_RATE_LO_BIT] <= rate_select_lo_ff;
                        rdata_ff[CTRL_RATE_HI_BIT] <= rate_select_hi_ff;
                        rdata_ff[CTRL_BIPOLAR_BIT] <= bipolar_ff;
                        rdata_ff[CTRL_ENABLE_BIT] <= enable_ff;
                    end
                    ADDR_STATUS: begin
                        rdata_ff[ST_SETTLED_BIT] <= (state_ff == SDF_RUN);
                        rdata_ff[ST_AVAIL_BIT] <= fifo_out_valid;
                        rdata_ff[ST_OVERRUN_BIT] <= overrun_ff;
                        rdata_ff[ST_LEVEL_LSB +: 5] <= fifo_level;
                    end
                    ADDR_DATA: begin
                        if (fifo_out_valid) begin
                            rdata_ff[OUT_W-1:0] <= fifo_out_data;
                        end
                    end
                    default: begin
                        rdata_ff <= '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avail_ff <= 1'b0;
        end else begin
            avail_ff <= fifo_out_valid;
        end
    end

    assign reg_rdata = rdata_ff;
    assign data_avail = avail_ff;

    property p_mod_period;
        @(posedge mclk) disable iff (rst)
        mod_sample |-> ##1 !mod_sample [*8] ##120 mod_sample;
    endproperty
    a_mod_period: assert property (p_mod_period) else $error("modulator strobe period is not 128 clocks");

    property p_phase_bound;
        @(posedge mclk) disable iff (rst)
        phase_ff < n_cur;
    endproperty
    a_phase_bound: assert property (p_phase_bound) else $error("decimation phase beyond selected ratio");

    property p_word_at_notch;
        @(posedge mclk) disable iff (rst)
        dec_stb_ff |-> $past(mod_sample) && ($past(phase_ff) == $past(n_cur) - 1'b1) && (phase_ff == '0);
    endproperty
    a_word_at_notch: assert property (p_word_at_notch) else $error("output word not at end of N samples");

    property p_step_restart;
        @(posedge mclk) disable iff (rst)
        (cfg_change && !filter_clear) |=> (settle_cnt_ff == 3'h4) && (state_ff == SDF_SETTLE) && !scale_stb_ff;
    endproperty
    a_step_restart: assert property (p_step_restart) else $error("config change did not restart settling at four");

    property p_sync_settle;
        @(posedge mclk) disable iff (rst)
        (filter_sync && enable_ff) |=> (settle_cnt_ff == 3'h3) && (int3_ff == '0) && (phase_ff == '0);
    endproperty
    a_sync_settle: assert property (p_sync_settle) else $error("filter sync did not clear and arm three words");

    property p_no_early_word;
        @(posedge mclk) disable iff (rst)
        (dec_stb_ff && (state_ff == SDF_SETTLE) && (settle_cnt_ff > 3'h1)) |=> !scale_stb_ff;
    endproperty
    a_no_early_word: assert property (p_no_early_word) else $error("unsettled word delivered");

    property p_bipolar_mid;
        @(posedge mclk) disable iff (rst)
        (deliver && bipolar_ff && (sum_ff == '0)) |=> (code_ff == 16'h8000);
    endproperty
    a_bipolar_mid: assert property (p_bipolar_mid) else $error("bipolar zero not at midscale");

    property p_unipolar_zero;
        @(posedge mclk) disable iff (rst)
        (deliver && !bipolar_ff && (sum_ff <= 0)) |=> (code_ff == 16'h0000);
    endproperty
    a_unipolar_zero: assert property (p_unipolar_zero) else $error("unipolar low end not at code zero");

    property p_read_data;
        @(posedge mclk) disable iff (rst)
        fifo_pop |=> (reg_rdata[OUT_W-1:0] == $past(fifo_out_data)) ##1 (reg_rdata == '0 || $past(reg_rd));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not presented one cycle after read");

endmodule

// *** dv/sdf_mod_model.sv ***
`timescale 1ns/10ps
module sdf_mod_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mod_sample,
    input wire logic [3:0] pattern,
    output logic mod_bit
);
    logic [1:0] idx_ff;
    logic filler_ff;

    // The bit is meaningful only in the sample cycle; elsewhere the line toggles so a stale value never looks valid.
    assign mod_bit = mod_sample ? pattern[idx_ff] : filler_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idx_ff <= 2'h0;
        end else if (mod_sample) begin
            idx_ff <= idx_ff + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            filler_ff <= 1'b0;
        end else begin
            filler_ff <= ~filler_ff;
        end
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb import sdf_pkg::*; ;
    localparam int T3 = int'(DEC_N_3) * MOD_DIV;
    localparam int T2 = int'(DEC_N_2) * MOD_DIV;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic mod_bit;
    logic filter_sync = 1'b0;
    logic mod_sample;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic data_avail;
    logic [3:0] pattern = 4'h5;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;

    always #2.5 mclk = ~mclk;

    sdf_filter dut_u (.mclk(mclk), .rst(rst), .mod_bit(mod_bit), .filter_sync(filter_sync),
        .mod_sample(mod_sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_avail(data_avail));

    sdf_mod_model mod_u (.mclk(mclk), .rst(rst), .mod_sample(mod_sample), .pattern(pattern), .mod_bit(mod_bit));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            n_errors++;
            $display("[FAIL] watchdog expected finish seen hang");
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Returns once a word is waiting, giving up after lim cycles.
    task automatic wait_word(input int lim);
        int n;
        n = 0;
        while (data_avail !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        rd(ADDR_CTRL, d);
        chk("ctrl reset", {28'h0, CTRL_RESET}, d);
        @(posedge mclk);
        #1;
        chk("rdata idle", 32'h0, reg_rdata);
        rd(ADDR_STATUS, d);
        chk("status reset", 32'h0, d);
        rd(4'hc, d);
        chk("unmapped read", 32'h0, d);
        rd(ADDR_DATA, d);
        chk("empty data", 32'h0, d);
        wr(4'hc, 32'h7);
        rd(ADDR_CTRL, d);
        chk("unmapped write", {28'h0, CTRL_RESET}, d);
        for (int r = 3; r >= 0; r--) begin
            wr(ADDR_CTRL, 32'h8 | r);
            rd(ADDR_CTRL, d);
            chk("rate code", 32'h8 | r, d);
        end
    endtask

    // Density 3/4 gives half of full scale in straight binary.
    task automatic t_unipolar();
        logic [31:0] d;
        int t0;
        int t1;
        pattern <= 4'h7;
        t0 = cyc;
        wr(ADDR_CTRL, 32'hb);
        wait_word(5 * T3);
        chk_range("step settle", 4 * T3 - 128, 4 * T3 + 16, cyc - t0);
        t1 = cyc;
        rd(ADDR_DATA, d);
        chk("uni word", 32'h8000, d);
        repeat (2) @(posedge mclk);
        wait_word(2 * T3);
        chk_range("word period", T3, T3, cyc - t1);
        repeat (2 * T3 + 200) @(posedge mclk);
        rd(ADDR_STATUS, d);
        chk("status three", 32'h303, d);
        repeat (3) begin
            rd(ADDR_DATA, d);
            chk("queued word", 32'h8000, d);
        end
        rd(ADDR_STATUS, d);
        chk("status drained", 32'h1, d);
        rd(ADDR_DATA, d);
        chk("drained data", 32'h0, d);
    endtask

    // All ones in bipolar mode exceeds the code range and must clamp, not wrap.
    task automatic t_bipolar();
        logic [31:0] d;
        int t0;
        pattern <= 4'hf;
        t0 = cyc;
        wr(ADDR_CTRL, 32'hf);
        wait_word(5 * T3);
        chk_range("bip settle", 4 * T3 - 128, 4 * T3 + 16, cyc - t0);
        rd(ADDR_DATA, d);
        chk("bip clamp", 32'hffff, d);
    endtask

    task automatic t_sync();
        logic [31:0] d;
        int t0;
        pattern <= 4'h1;
        wr(ADDR_CTRL, 32'he);
        @(posedge mclk);
        filter_sync <= 1'b1;
        repeat (4) @(posedge mclk);
        filter_sync <= 1'b0;
        t0 = cyc;
        wait_word(4 * T2);
        chk_range("sync settle", 3 * T2 - 128, 3 * T2 + 16, cyc - t0);
        rd(ADDR_DATA, d);
        chk("bip quarter", 32'h4000, d);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_unipolar();
        t_bipolar();
        t_sync();
        complete_run();
    end
endmodule
